// File: logic/updown_pkg.sv
// Constants and types shared by the up/down counter and its register slave
package updown_pkg;

   // Counter geometry
   localparam int COUNT_W = 3;
   localparam logic [2:0] COUNT_ZERO = 3'h0;
   localparam logic [2:0] COUNT_MAX = 3'h7;
   localparam logic [2:0] COUNT_ONE = 3'h1;
   localparam logic [2:0] MARK_FROM = 3'h5;
   localparam logic [2:0] MARK_TO = 3'h6;

   // Direction codes, pattern {count_up, count_down}
   typedef enum logic [1:0] {
      dir_reset_code = 2'b00,
      dir_decrement_code = 2'b01,
      dir_increment_code = 2'b10,
      dir_hold_code = 2'b11
   } dir_mode_t;

   // Bus geometry
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;

   // Register byte addresses
   localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
   localparam logic [31:0] WORD_MASK = 32'hffff_fffc;

   // Control register fields
   localparam int CTRL_OVR_BIT = 0;
   localparam int CTRL_DIR_LSB = 1;
   localparam int CTRL_DIR_MSB = 2;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [31:0] CTRL_RD_MASK = 32'h0000_0007;

   // Status register fields
   localparam int STAT_CNT_LSB = 0;
   localparam int STAT_CNT_MSB = 2;
   localparam int STAT_TC_BIT = 3;
   localparam int STAT_MARK_BIT = 4;
   localparam int STAT_DIR_LSB = 5;
   localparam int STAT_DIR_MSB = 6;

   // Response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: logic/reg_access_if.sv
// Register access strobes between the bus slave and the counter core
`timescale 1ns/100ps
interface reg_access_if;
   import updown_pkg::*;

   logic wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [STRB_W-1:0] wr_strb;
   logic wr_ok;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic rd_ok;

   modport bus
   (
      output wr_en,
      output wr_addr,
      output wr_data,
      output wr_strb,
      input wr_ok,
      output rd_en,
      output rd_addr,
      input rd_data,
      input rd_ok
   );

   modport regs
   (
      input wr_en,
      input wr_addr,
      input wr_data,
      input wr_strb,
      output wr_ok,
      input rd_en,
      input rd_addr,
      output rd_data,
      output rd_ok
   );

endinterface

// File: logic/axil_slave.sv
// AXI4-Lite slave front end issuing single-cycle register strobes
`timescale 1ns/100ps
module axil_slave
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address
   input wire logic [updown_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // Write data
   input wire logic [updown_pkg::DATA_W-1:0] wdata,
   input wire logic [updown_pkg::STRB_W-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read address
   input wire logic [updown_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // Read data
   output logic [updown_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   reg_access_if.bus ra
);
   import updown_pkg::*;

   logic aw_held_reg;
   logic w_held_reg;
   logic ar_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [STRB_W-1:0] wstrb_reg;
   logic [ADDR_W-1:0] araddr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Handshake decode
   wire aw_take = awvalid && awready;
   wire w_take = wvalid && wready;
   wire ar_take = arvalid && arready;
   wire b_done = bvalid && bready;
   wire r_done = rvalid && rready;
   wire wr_fire = aw_held_reg && w_held_reg && !bvalid;
   wire rd_fire = ar_held_reg && !rvalid;
   wire aw_held_next = (aw_held_reg || aw_take) && !wr_fire;
   wire w_held_next = (w_held_reg || w_take) && !wr_fire;
   wire ar_held_next = (ar_held_reg || ar_take) && !rd_fire;
   wire bvalid_next = wr_fire || (bvalid && !bready);
   wire rvalid_next = rd_fire || (rvalid && !rready);

   assign ra.wr_en = wr_fire;
   assign ra.wr_addr = awaddr_reg;
   assign ra.wr_data = wdata_reg;
   assign ra.wr_strb = wstrb_reg;
   assign ra.rd_en = rd_fire;
   assign ra.rd_addr = araddr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Channel state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         ar_held_reg <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         arready <= 1'b0;
         bvalid <= 1'b0;
         rvalid <= 1'b0;
      end
      else
      begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         ar_held_reg <= ar_held_next;
         awready <= !aw_held_next && !bvalid_next;
         wready <= !w_held_next && !bvalid_next;
         arready <= !ar_held_next && !rvalid_next;
         bvalid <= bvalid_next;
         rvalid <= rvalid_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Payload capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         araddr_reg <= '0;
         bresp <= RESP_OKAY;
         rresp <= RESP_OKAY;
         rdata <= '0;
      end
      else
      begin
         if (aw_take)
            awaddr_reg <= awaddr;
         if (w_take)
         begin
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (ar_take)
            araddr_reg <= araddr;
         if (wr_fire)
            bresp <= ra.wr_ok ? RESP_OKAY : RESP_SLVERR;
         if (rd_fire)
         begin
            rdata <= ra.rd_data;
            rresp <= ra.rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (r_done)
            rdata <= '0;
         if (b_done && !wr_fire)
            bresp <= RESP_OKAY;
      end
   end

endmodule

// File: logic/updown_counter_3bit.sv
// Three-bit up/down counter with terminal count, marker and register slave
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module updown_counter_3bit
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Direction inputs from surrounding logic
   input wire logic count_up,
   input wire logic count_down,
   // Counter outputs
   output logic [updown_pkg::COUNT_W-1:0] count_value,
   output logic count_bit_msb,
   output logic count_bit_lsb,
   output logic terminal_count,
   output logic step_marker,
   // AXI4-Lite write address
   input wire logic [updown_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [updown_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [updown_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [updown_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [updown_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import updown_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   reg_access_if ra ();

   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] count_next;
   logic tc_reg;
   logic tc_next;
   logic mark_reg;
   logic mark_next;
   dir_mode_t dir_reg;
   logic ovr_reg;
   logic ovr_next;
   dir_mode_t ovr_dir_reg;
   dir_mode_t ovr_dir_next;
   dir_mode_t pin_dir;
   dir_mode_t eff_dir;

   ////////////////////////////////////////////////////////////////////////////
   // Bus front end
   axil_slave u_slave
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .ra(ra)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Direction selection
   assign pin_dir = dir_mode_t'({count_up, count_down});
   assign eff_dir = ovr_reg ? ovr_dir_reg : pin_dir;

   ////////////////////////////////////////////////////////////////////////////
   // Next count
   function automatic logic [COUNT_W-1:0] step_count(input dir_mode_t mode, input logic [COUNT_W-1:0] cur);
      logic [COUNT_W-1:0] res;
      res = cur;
      unique case (mode)
         dir_increment_code:
         begin
            res = cur + COUNT_ONE;
         end
         dir_decrement_code:
         begin
            res = cur - COUNT_ONE;
         end
         dir_hold_code:
         begin
            res = cur;
         end
         dir_reset_code:
         begin
            res = COUNT_ZERO;
         end
      endcase
      return res;
   endfunction

   assign count_next = step_count(eff_dir, count_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Terminal count for the state entered at this edge
   wire tc_up = (eff_dir == dir_increment_code) && (count_next == COUNT_MAX);
   wire tc_down = (eff_dir == dir_decrement_code) && (count_next == COUNT_ZERO);
   assign tc_next = tc_up || tc_down;

   ////////////////////////////////////////////////////////////////////////////
   // Marker on the five-to-six step
   wire mark_step = (eff_dir == dir_increment_code) && (count_reg == MARK_FROM) && (count_next == MARK_TO);
   assign mark_next = mark_reg || mark_step;

   ////////////////////////////////////////////////////////////////////////////
   // Counter state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         count_reg <= COUNT_ZERO;
         tc_reg <= 1'b0;
         mark_reg <= 1'b0;
         dir_reg <= dir_reset_code;
      end
      else
      begin
         count_reg <= count_next;
         tc_reg <= tc_next;
         mark_reg <= mark_next;
         dir_reg <= eff_dir;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire [ADDR_W-1:0] wr_word = ra.wr_addr & WORD_MASK;
   wire [ADDR_W-1:0] rd_word = ra.rd_addr & WORD_MASK;
   wire wr_ctrl = (wr_word == CTRL_OFFSET);
   wire wr_status = (wr_word == STATUS_OFFSET);
   wire rd_ctrl = (rd_word == CTRL_OFFSET);
   wire rd_status = (rd_word == STATUS_OFFSET);
   wire ctrl_load = ra.wr_en && wr_ctrl && ra.wr_strb[0];

   assign ra.wr_ok = wr_ctrl || wr_status;
   assign ra.rd_ok = rd_ctrl || rd_status;

   assign ovr_next = ctrl_load ? ra.wr_data[CTRL_OVR_BIT] : ovr_reg;
   assign ovr_dir_next = ctrl_load ? dir_mode_t'(ra.wr_data[CTRL_DIR_MSB:CTRL_DIR_LSB]) : ovr_dir_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   wire [DATA_W-1:0] ctrl_word = {29'h0, ovr_dir_reg, ovr_reg} & CTRL_RD_MASK;
   wire [DATA_W-1:0] status_word = {25'h0, dir_reg, mark_reg, tc_reg, count_reg};

   assign ra.rd_data = rd_ctrl ? ctrl_word : (rd_status ? status_word : '0);

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ovr_reg <= CTRL_RESET[CTRL_OVR_BIT];
         ovr_dir_reg <= dir_mode_t'(CTRL_RESET[CTRL_DIR_MSB:CTRL_DIR_LSB]);
      end
      else
      begin
         ovr_reg <= ovr_next;
         ovr_dir_reg <= ovr_dir_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign count_value = count_reg;
   assign count_bit_msb = count_reg[STAT_CNT_MSB];
   assign count_bit_lsb = count_reg[STAT_CNT_LSB];
   assign terminal_count = tc_reg;
   assign step_marker = mark_reg;

endmodule

// File: verif/updown_counter_3bit_sva.sv
// Assertions on the counter pins
`timescale 1ns/100ps
module updown_counter_3bit_sva
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Counter pins
   input wire logic count_up,
   input wire logic count_down,
   input wire logic [updown_pkg::COUNT_W-1:0] count_value,
   input wire logic count_bit_msb,
   input wire logic count_bit_lsb,
   input wire logic terminal_count,
   input wire logic step_marker
);
   import updown_pkg::*;
   wire logic [1:0] dir = {count_up, count_down};
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ///////////////////////////////////////////////
   // Antecedents of the count, terminal and marker-set checks also need reset released at the starting edge
   count_bits_a:
   assert property (count_bit_msb == count_value[2] && count_bit_lsb == count_value[0]) else $error("bit copy");
   count_up_a:
   assert property (aresetn && dir == dir_increment_code |=> count_value == $past(count_value) + COUNT_ONE)
      else $error("up");
   count_wrap_a:
   assert property (aresetn && dir == dir_increment_code && count_value == COUNT_MAX |=> count_value == COUNT_ZERO)
      else $error("wrap");
   count_down_a:
   assert property (aresetn && dir == dir_decrement_code |=> count_value == $past(count_value) - COUNT_ONE)
      else $error("down");
   count_hold_a:
   assert property (aresetn && dir == dir_hold_code |=> $stable(count_value)) else $error("hold");
   count_clear_a:
   assert property (aresetn && dir == dir_reset_code |=> count_value == COUNT_ZERO) else $error("clear");
   term_count_a:
   assert property (aresetn |=> terminal_count == (($past(dir) == dir_increment_code && count_value == COUNT_MAX)
      || ($past(dir) == dir_decrement_code && count_value == COUNT_ZERO))) else $error("terminal");
   marker_set_a:
   assert property (aresetn && dir == dir_increment_code && count_value == MARK_FROM |=> step_marker)
      else $error("marker");
   marker_cause_a:
   assert property ($rose(step_marker) |-> $past(count_value) == MARK_FROM) else $error("marker cause");
   marker_stick_a:
   assert property (step_marker |=> step_marker) else $error("marker lost");
   reset_clear_a:
   assert property (disable iff (1'b0) !aresetn |=> count_value == COUNT_ZERO && !step_marker && !terminal_count)
      else $error("reset");
endmodule

bind updown_counter_3bit updown_counter_3bit_sva chk
(
   .aclk(aclk), .aresetn(aresetn), .count_up(count_up), .count_down(count_down), .count_value(count_value),
   .count_bit_msb(count_bit_msb), .count_bit_lsb(count_bit_lsb), .terminal_count(terminal_count),
   .step_marker(step_marker)
);

// File: verif/dir_source.sv
// Surrounding logic driving the direction pins
`timescale 1ns/100ps
module dir_source
(
   // Clock
   input wire logic aclk,
   // Direction pins
   output logic count_up,
   output logic count_down
);
   import updown_pkg::*;
   initial
   begin
      count_up = 1'h1;
      count_down = 1'h1;
   end
   // Mode held for n sampling edges
   task automatic run(input dir_mode_t m, input int n);
      @(posedge aclk);
      {count_up, count_down} <= m;
      repeat (n - 1) @(posedge aclk);
   endtask
endmodule

// File: verif/updown_counter_3bit_test.sv
// Bench for the up/down counter
`timescale 1ns/100ps
module updown_counter_3bit_test;
   import updown_pkg::*;
   logic aclk, aresetn, count_up, count_down, count_bit_msb, count_bit_lsb, terminal_count, step_marker;
   logic [COUNT_W-1:0] count_value, exp_count, nxt;
   logic [31:0] s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_rdata, rd_word;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, exp_tc, exp_mark, chk_on;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   wire logic [1:0] mode = {count_up, count_down};
   ///////////////////////////////////////////////
   updown_counter_3bit dut
   (
      .aclk(aclk), .aresetn(aresetn), .count_up(count_up), .count_down(count_down),
      .count_value(count_value), .count_bit_msb(count_bit_msb), .count_bit_lsb(count_bit_lsb),
      .terminal_count(terminal_count), .step_marker(step_marker), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );
   dir_source src
   (
      .aclk(aclk), .count_up(count_up), .count_down(count_down)
   );
   initial
   begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end
   // Reference count
   always_comb
   begin
      case (mode)
         dir_increment_code: nxt = exp_count + 3'h1;
         dir_decrement_code: nxt = exp_count - 3'h1;
         dir_hold_code: nxt = exp_count;
         default: nxt = 3'h0;
      endcase
   end
   always @(posedge aclk)
   begin
      exp_count <= aresetn ? nxt : 3'h0;
      exp_tc <= aresetn && ((mode == 2'h2 && nxt == 3'h7) || (mode == 2'h1 && nxt == 3'h0));
      exp_mark <= aresetn && (exp_mark || (mode == 2'h2 && exp_count == 3'h5));
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         failures++;
         test_done;
      end
   end
   always @(negedge aclk)
   begin
      if (chk_on)
      begin
         check("count", {29'h0, count_value}, {29'h0, exp_count});
         check("bits", {30'h0, count_bit_msb, count_bit_lsb}, {30'h0, exp_count[2], exp_count[0]});
         check("terminal", {31'h0, terminal_count}, {31'h0, exp_tc});
         check("marker", {31'h0, step_marker}, {31'h0, exp_mark});
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   task automatic axi_read(input logic [31:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
      end
      while (s_axi_rvalid !== 1'h1);
      rd_word = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic test_done;
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      {aresetn, chk_on, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hf;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      chk_on = 1'h1;
      src.run(dir_increment_code, 9);
      src.run(dir_hold_code, 3);
      src.run(dir_decrement_code, 10);
      src.run(dir_increment_code, 3);
      src.run(dir_reset_code, 1);
      src.run(dir_increment_code, 2);
      src.run(dir_hold_code, 1);
      axi_read(STATUS_OFFSET);
      check("status", rd_word, {25'h0, mode, exp_mark, exp_tc, exp_count});
      axi_write(CTRL_OFFSET, 32'h6, RESP_OKAY);
      axi_read(CTRL_OFFSET);
      check("ctrl", rd_word, 32'h6);
      // Write with byte lane 0 off must leave control untouched
      s_axi_wstrb <= 4'he;
      axi_write(CTRL_OFFSET, 32'h0, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      axi_read(CTRL_OFFSET);
      check("ctrl strobe", rd_word, 32'h6);
      axi_write(STATUS_OFFSET, 32'h1, RESP_OKAY);
      axi_write(32'h10, 32'h1, RESP_SLVERR);
      axi_read(32'h10);
      check("rresp", {30'h0, rd_resp}, {30'h0, RESP_SLVERR});
      check("rdata", rd_word, 32'h0);
      axi_write(CTRL_OFFSET, 32'h0, RESP_OKAY);
      src.run(dir_decrement_code, 4);
      aresetn <= 1'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      src.run(dir_increment_code, 8);
      src.run(dir_decrement_code, 2);
      test_done;
   end
endmodule
